// ### hw/sds_top.v
// sleep control and diagnostic status register bank with its serial frame checker
// ----------------------------------------
// Functional notes
// - all ones in low byte sleeps forever
// - chip select fall or reset pulse wakes
// - other value sleeps value times half second
// - flag reads one while condition exists
// - status read returns flags then clears them
// - persisting fault sets flag after next sample
// - bit three flags bit counts not sixteen-multiple
// - two alarm flags, one per alarm
// - checksum mismatch flag
// - self-test failure flag
// - rate over-range flag
// - flash update failure flag
// - status reads zero after reset
// - fixed read-only part code
// - three read-only lot code words
// - serial number fourteen bits, top two zero
// - checksum result at status bit six
// - self-test result at status bit five
// ----------------------------------------
`timescale 1ns/1ps
`include "sds_regs.vh"
module sds_top #(
  parameter [15:0] PART_CODE = 16'h1234, // arbitrary neutral value
  parameter [15:0] LOT_CODE_1 = 16'h0001, // arbitrary lot value
  parameter [15:0] LOT_CODE_2 = 16'h0002, // arbitrary lot value
  parameter [15:0] LOT_CODE_3 = 16'h0003, // arbitrary lot value
  parameter [15:0] UNIT_NUMBER = 16'h0001, // arbitrary, 1 to 9999
  parameter LSB_CYCLES = `SDS_SLEEP_LSB_CYCLES
) (
  input wire clock,
  input wire reset_n,
  input wire cs_n,
  input wire sclk,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire sample_done,
  input wire alarm1_active,
  input wire alarm2_active,
  input wire checksum_done,
  input wire checksum_bad,
  input wire self_test_done,
  input wire self_test_bad,
  input wire over_range,
  input wire flash_done,
  input wire flash_bad,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  output reg asleep,
  output reg sleep_timed,
  output reg wake_pulse
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire cs_n_s; // chip select, synchronised
  wire sclk_s; // serial clock, synchronised

  sds_sync #(.RESET_VALUE(1'b1)) u_sync_cs (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(cs_n),
    .sync_out(cs_n_s)
  );

  sds_sync #(.RESET_VALUE(1'b0)) u_sync_sclk (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(sclk),
    .sync_out(sclk_s)
  );

  reg cs_n_q; // previous chip select level
  reg sclk_q; // previous serial clock level
  reg [3:0] edge_cnt_q; // rising edges modulo sixteen
  reg in_frame_q; // chip select is low
  reg spi_err_q; // pending frame error event

  wire cs_fall = cs_n_q & ~cs_n_s; // frame starts
  wire cs_rise = ~cs_n_q & cs_n_s; // frame ends
  wire sclk_rise = ~sclk_q & sclk_s; // one bit clocked

  // ----------------------------------------
  // frame bit counter
  // ----------------------------------------
  // only the low four bits matter, a full count is not needed
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      edge_cnt_q <= 4'h0;
      in_frame_q <= 1'b0;
      spi_err_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
      spi_err_q <= 1'b0;
      if (cs_fall) begin
        in_frame_q <= 1'b1;
        edge_cnt_q <= 4'h0;
      end else if (cs_rise) begin
        in_frame_q <= 1'b0;
        // a remainder means the frame was not whole words
        spi_err_q <= (edge_cnt_q != 4'h0);
      end else if (in_frame_q && sclk_rise) begin
        edge_cnt_q <= edge_cnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // sleep control register and timer
  // ----------------------------------------
  reg [15:0] sleep_control_q; // stored sleep control word
  wire sleep_wr = reg_wr && (reg_addr == `SDS_OFF_SLEEP_CONTROL);
  wire wake_event = cs_fall;
  wire asleep_w;
  wire timed_w;
  wire wake_w;

  // write of the control word arms the timer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sleep_control_q <= 16'h0000;
    end else if (sleep_wr) begin
      sleep_control_q <= {8'h00, reg_wdata[7:0]};
    end
  end

  // reset_n low already returns everything awake, so a reset pulse wakes too
  sds_sleep_timer #(.LSB_CYCLES(LSB_CYCLES)) u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .start(sleep_wr),
    .sleep_value(reg_wdata[7:0]),
    .wake(wake_event),
    .asleep_q(asleep_w),
    .timed_q(timed_w),
    .wake_pulse_q(wake_w)
  );

  // ----------------------------------------
  // diagnostic flags
  // ----------------------------------------
  reg [15:0] diag_q; // sticky error flags
  reg [15:0] diag_d;
  wire diag_rd = reg_rd && (reg_addr == `SDS_OFF_DIAG_FLAGS);

  // set beats clear: an event in the read cycle survives the clear
  always @* begin
    diag_d = diag_q;
    if (diag_rd) begin
      diag_d = `SDS_DIAG_RESET;
    end
    // levels re-assert at each completed sample while still present
    if (sample_done) begin
      if (alarm1_active) diag_d[`SDS_BIT_ALARM1] = 1'b1;
      if (alarm2_active) diag_d[`SDS_BIT_ALARM2] = 1'b1;
      if (over_range) diag_d[`SDS_BIT_OVER_RANGE] = 1'b1;
      if (checksum_bad) diag_d[`SDS_BIT_CHECKSUM] = 1'b1;
      if (self_test_bad) diag_d[`SDS_BIT_SELF_TEST] = 1'b1;
    end
    // checksum and self-test results land when the test ends, pass clears, fail sets; flash fail only sets
    if (checksum_done) diag_d[`SDS_BIT_CHECKSUM] = checksum_bad;
    if (self_test_done) diag_d[`SDS_BIT_SELF_TEST] = self_test_bad;
    if (flash_done && flash_bad) diag_d[`SDS_BIT_FLASH_FAIL] = 1'b1;
    if (spi_err_q) diag_d[`SDS_BIT_SPI_FAIL] = 1'b1;
  end

  // flags are one only while reporting a fault
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      diag_q <= `SDS_DIAG_RESET;
    end else begin
      diag_q <= diag_d;
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  reg [15:0] rdata_d;

  // unmapped addresses answer zero
  always @* begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `SDS_OFF_DIAG_FLAGS: rdata_d = diag_q;
      `SDS_OFF_LOT_CODE_1: rdata_d = LOT_CODE_1;
      `SDS_OFF_LOT_CODE_2: rdata_d = LOT_CODE_2;
      `SDS_OFF_LOT_CODE_3: rdata_d = LOT_CODE_3;
      `SDS_OFF_PART_CODE: rdata_d = PART_CODE;
      `SDS_OFF_UNIT_NUMBER: rdata_d = UNIT_NUMBER & `SDS_SERIAL_MASK;
      `SDS_OFF_SLEEP_CONTROL: rdata_d = sleep_control_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      asleep <= 1'b0;
      sleep_timed <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      asleep <= asleep_w;
      sleep_timed <= timed_w;
      wake_pulse <= wake_w;
    end
  end
endmodule // sds_top

// ### hw/sds_regs.vh
// register offsets, field positions, reset values and timing counts for sleep and status
`ifndef SDS_REGS_VH
`define SDS_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SDS_OFF_SLEEP_CONTROL 8'h24
`define SDS_OFF_DIAG_FLAGS 8'h26
`define SDS_OFF_LOT_CODE_1 8'h32
`define SDS_OFF_LOT_CODE_2 8'h34
`define SDS_OFF_LOT_CODE_3 8'h36
`define SDS_OFF_PART_CODE 8'h38
`define SDS_OFF_UNIT_NUMBER 8'h3A
// ----------------------------------------
// field values and positions
// ----------------------------------------
`define SDS_SLEEP_FOREVER 8'hFF
`define SDS_BIT_FLASH_FAIL 1
`define SDS_BIT_SPI_FAIL 3
`define SDS_BIT_OVER_RANGE 4
`define SDS_BIT_SELF_TEST 5
`define SDS_BIT_CHECKSUM 6
`define SDS_BIT_ALARM1 8
`define SDS_BIT_ALARM2 9
`define SDS_DIAG_RESET 16'h0000
`define SDS_SERIAL_MASK 16'h3FFF
`define SDS_SPI_WORD_BITS 16
// ----------------------------------------
// timing
// ----------------------------------------
`define SDS_CLK_HZ 50000000
`define SDS_SLEEP_LSB_MS 500
`define SDS_SLEEP_LSB_CYCLES ((`SDS_CLK_HZ / 1000) * `SDS_SLEEP_LSB_MS)
`endif

// ### hw/sds_sync.v
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sds_sync #(
  parameter RESET_VALUE = 1'b0
) (
  input wire clock,
  input wire reset_n,
  input wire async_in,
  output reg sync_out
);
  reg meta_q; // first stage, read only by second stage

  // the first stage may go metastable; only sync_out leaves this module
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sds_sync

// ### hw/sds_sleep_timer.v
// sleep state and half-second interval timer
`timescale 1ns/1ps
`include "sds_regs.vh"
module sds_sleep_timer #(
  parameter LSB_CYCLES = `SDS_SLEEP_LSB_CYCLES
) (
  input wire clock,
  input wire reset_n,
  input wire start,
  input wire [7:0] sleep_value,
  input wire wake,
  output reg asleep_q,
  output reg timed_q,
  output reg wake_pulse_q
);
  reg [31:0] tick_q; // cycles inside current half second
  reg [7:0] units_q; // half seconds still to sleep

  // ----------------------------------------
  // sleep state machine
  // ----------------------------------------
  // a start in the same cycle as a wake is taken, since the write is newer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      asleep_q <= 1'b0;
      timed_q <= 1'b0;
      wake_pulse_q <= 1'b0;
      tick_q <= 32'h0000_0000;
      units_q <= 8'h00;
    end else begin
      wake_pulse_q <= 1'b0;
      if (start) begin
        // forever for all ones, otherwise count half seconds
        asleep_q <= 1'b1;
        timed_q <= (sleep_value != `SDS_SLEEP_FOREVER);
        units_q <= sleep_value;
        tick_q <= 32'h0000_0000;
      end else if (asleep_q && wake) begin
        // chip select or reset line ends any sleep
        asleep_q <= 1'b0;
        timed_q <= 1'b0;
        wake_pulse_q <= 1'b1;
      end else if (asleep_q && timed_q) begin
        if (units_q == 8'h00) begin
          // interval over: resume without host action; zero sleeps no time
          asleep_q <= 1'b0;
          timed_q <= 1'b0;
          wake_pulse_q <= 1'b1;
        end else if (tick_q == LSB_CYCLES - 1) begin
          tick_q <= 32'h0000_0000;
          units_q <= units_q - 8'h01;
        end else begin
          tick_q <= tick_q + 32'h0000_0001;
        end
      end
    end
  end
endmodule // sds_sleep_timer

// ### dv/sds_host_model.sv
// host side model: drives chip select and serial clock frames
`timescale 1ns/1ps
module sds_host_model (
  input wire clock,
  output logic cs_n,
  output logic sclk
);
  // deselected, serial clock idles low and stands still between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // one frame with the given count of serial clock pulses; a count not a multiple of sixteen breaks framing
  task automatic frame(input int edges);
    @(posedge clock);
    #1 cs_n = 1'b0; // falling select also wakes a sleeping device
    repeat (edges) begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
  endtask
endmodule // sds_host_model

// ### dv/sds_top_monitor.sv
// port checker for the sleep and status register bank
`timescale 1ns/1ps
`include "sds_regs.vh"
module sds_top_monitor #(
  parameter LSB_CYCLES = 10
) (
  input wire clock,
  input wire reset_n,
  input wire cs_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire reg_rvalid,
  input wire asleep,
  input wire sleep_timed,
  input wire wake_pulse
);
  localparam int LO = LSB_CYCLES; // shortest legal one-unit sleep
  localparam int HI = LSB_CYCLES + 6; // allows for pin and wake latency
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire slp_wr = reg_wr && (reg_addr == `SDS_OFF_SLEEP_CONTROL); // sleep control write
  wire [7:0] slp_val = reg_wdata[7:0]; // only the low byte counts
  property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rv_cause; reg_rvalid |-> $past(reg_rd); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
  property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_forever; slp_wr && slp_val == 8'hff |-> ##2 asleep && !sleep_timed; endproperty
  a_forever: assert property (p_forever) else $error("no endless sleep");
  property p_timed; slp_wr && slp_val != 8'hff && slp_val != 8'h00 |-> ##2 asleep && sleep_timed;
  endproperty
  a_timed: assert property (p_timed) else $error("no timed sleep");
  property p_stay; (asleep && !sleep_timed && cs_n && !reg_wr)[*6] |=> asleep; endproperty
  a_stay: assert property (p_stay) else $error("endless sleep ended");
  property p_cs_wake; asleep && $fell(cs_n) |-> ##[1:8] !asleep; endproperty
  a_cs_wake: assert property (p_cs_wake) else $error("select did not wake");
  property p_expiry; slp_wr && slp_val == 8'h01 |-> ##[LO:HI] wake_pulse; endproperty
  a_expiry: assert property (p_expiry) else $error("timed sleep did not expire");
  property p_wake; wake_pulse |-> !asleep && $past(asleep); endproperty
  a_wake: assert property (p_wake) else $error("wake pulse without wake");
  property p_pulse1; wake_pulse |=> !wake_pulse; endproperty
  a_pulse1: assert property (p_pulse1) else $error("wake pulse too long");
endmodule // sds_top_monitor
bind sds_top sds_top_monitor #(.LSB_CYCLES(LSB_CYCLES)) u_sds_top_monitor (
  .clock(clock), .reset_n(reset_n), .cs_n(cs_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .asleep(asleep), .sleep_timed(sleep_timed), .wake_pulse(wake_pulse));

// ### dv/tb_top.sv
// testbench: register, flag, frame and sleep scenarios for the status bank
`timescale 1ns/1ps
`include "sds_regs.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  localparam LSB = 10; // short sleep unit keeps the run brief
  localparam [7:0] DG = `SDS_OFF_DIAG_FLAGS;
  localparam [7:0] SC = `SDS_OFF_SLEEP_CONTROL;
  localparam [15:0] PART = 16'h5a5a; // arbitrary value
  localparam [15:0] UNIT = 16'h270f; // largest legal unit number
  logic clock, reset_n, reg_wr, reg_rd, smp, cks, stt, fls;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [5:0] cond; // flash, range, self test, checksum, alarm 1, alarm 2
  wire cs_n, sclk, reg_rvalid, asleep, sleep_timed, wake_pulse;
  wire [15:0] reg_rdata;
  int miscompares = 0;
  int num_checks = 0;
  sds_top #(.PART_CODE(PART), .LOT_CODE_1(16'h1111), .UNIT_NUMBER(UNIT),
    .LSB_CYCLES(LSB)) u_sds_top (
    .clock(clock), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sample_done(smp),
    .alarm1_active(cond[4]), .alarm2_active(cond[5]), .checksum_done(cks),
    .checksum_bad(cond[3]), .self_test_done(stt), .self_test_bad(cond[2]),
    .over_range(cond[1]), .flash_done(fls), .flash_bad(cond[0]), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .asleep(asleep), .sleep_timed(sleep_timed),
    .wake_pulse(wake_pulse));
  sds_host_model u_sds_host_model (.clock(clock), .cs_n(cs_n), .sclk(sclk));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // inputs always move one nanosecond after the rising edge
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    step();
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    step();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ex, input string nm);
    step();
    {reg_rd, reg_addr} = {1'b1, a};
    step();
    reg_rd = 1'b0;
    `CHK("read valid", 1'b1, reg_rvalid)
    `CHK(nm, ex, reg_rdata)
  endtask
  // a completed sample cycle with every test ending at once
  task automatic tick();
    step();
    {smp, cks, stt, fls} = 4'hf;
    step();
    {smp, cks, stt, fls} = 4'h0;
  endtask
  task automatic test_ids();
    rd(DG, `SDS_DIAG_RESET, "flags at reset");
    rd(`SDS_OFF_PART_CODE, PART, "part code");
    rd(`SDS_OFF_LOT_CODE_1, 16'h1111, "lot 1");
    rd(`SDS_OFF_LOT_CODE_2, 16'h0002, "lot 2");
    rd(`SDS_OFF_LOT_CODE_3, 16'h0003, "lot 3");
    rd(`SDS_OFF_UNIT_NUMBER, UNIT & `SDS_SERIAL_MASK, "unit number");
    wr(`SDS_OFF_PART_CODE, 16'h0000); // read-only place must ignore this
    rd(`SDS_OFF_PART_CODE, PART, "part after write");
    rd(8'h10, 16'h0000, "unmapped");
    $display("test_ids done");
  endtask
  // each fault alone: set, read-clear, set again while it persists, then normal
  task automatic test_flags();
    int bp[6] = '{1, 4, 5, 6, 8, 9};
    for (int k = 0; k < 6; k++) begin
      cond = 6'h01 << k;
      tick();
      rd(DG, 16'h0001 << bp[k], "flag set");
      rd(DG, 16'h0000, "flag cleared");
      tick();
      rd(DG, 16'h0001 << bp[k], "flag again");
      cond = 6'h00;
      tick();
      rd(DG, 16'h0000, "flag normal");
    end
    $display("test_flags done");
  endtask
  task automatic test_frame();
    u_sds_host_model.frame(16);
    repeat (8) step();
    rd(DG, 16'h0000, "whole frame");
    u_sds_host_model.frame(17);
    repeat (8) step();
    rd(DG, 16'h0001 << `SDS_BIT_SPI_FAIL, "broken frame");
    $display("test_frame done");
  endtask
  task automatic test_sleep();
    int n;
    logic [15:0] vals[2] = '{16'hab01, 16'h0003}; // upper byte must not count
    wr(SC, 16'h00ff);
    step();
    `CHK("endless timed", 1'b0, sleep_timed)
    repeat (40) step();
    `CHK("still asleep", 1'b1, asleep)
    u_sds_host_model.frame(16);
    `CHK("select wake", 1'b0, asleep)
    foreach (vals[i]) begin
      wr(SC, vals[i]);
      n = 1;
      while (wake_pulse !== 1'b1 && n < 200) begin
        step();
        n++;
      end
      `CHK("sleep span", 1'b1, n >= vals[i][7:0] * LSB && n <= vals[i][7:0] * LSB + 6)
    end
    rd(SC, 16'h0003, "sleep word");
    wr(SC, 16'h00fe);
    u_sds_host_model.frame(16);
    `CHK("early wake", 1'b0, asleep)
    wr(SC, 16'h00ff);
    step();
    reset_n = 1'b0;
    step();
    `CHK("reset wake", 1'b0, asleep)
    reset_n = 1'b1;
    $display("test_sleep done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog: the tests need well under ten thousand cycles
  initial begin
    #400000;
    miscompares++;
    $display("ERROR watchdog expected end seen hang");
    report_and_stop();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, smp, cks, stt, fls} = 7'h00;
    {reg_addr, reg_wdata, cond} = 30'h0;
    repeat (16) @(posedge clock);
    #1 reset_n = 1'b1;
    test_ids();
    test_flags();
    test_frame();
    test_sleep();
    report_and_stop();
  end
endmodule // tb_top
